// *** srsc_pkg.sv ***
package srsc_pkg;
	// register location and reset value
	localparam logic [7:0] CTRL_ADDR = 8'h2b;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// field positions inside the control register
	localparam int SELF_TEST_BIT = 7;
	localparam int RST_BIT = 6;
	localparam int SPARE_BIT = 5;
	localparam int SMODS_LSB = 3;
	localparam int SLPE_BIT = 2;
	localparam int MODS_LSB = 0;
	// oversampling power modes
	localparam logic [1:0] OSR_NORMAL = 2'h0;
	localparam logic [1:0] OSR_LNLP = 2'h1;
	localparam logic [1:0] OSR_HIRES = 2'h2;
	localparam logic [1:0] OSR_LOWPWR = 2'h3;
	// timing: clock period and boot duration
	localparam int CLK_PERIOD_NS = 4;
	localparam int BOOT_TIME_NS = 64;
	localparam int BOOT_CYCLES = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BOOT_CNT_W = 8;
	localparam logic [BOOT_CNT_W-1:0] BOOT_LAST = BOOT_CNT_W'(BOOT_CYCLES - 1);
	// host quiet time after a reset, kept for reference by the host side
	localparam int HOST_WAIT_US = 1;
	localparam int HOST_WAIT_CYCLES = HOST_WAIT_US * 1000 / CLK_PERIOD_NS;
	// reset sequencer states
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_STBY = 3'b010,
		SEQ_BOOT = 3'b100
	} srsc_state_t;
endpackage

// *** srsc_boot_timer.sv ***
module srsc_boot_timer (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// control
	input wire logic start_in,
	output logic busy_out,
	output logic done_out
);
	logic [srsc_pkg::BOOT_CNT_W-1:0] cnt_reg;
	logic [srsc_pkg::BOOT_CNT_W-1:0] cnt_next;
	logic busy_next;
	wire at_last = busy_out && (cnt_reg == srsc_pkg::BOOT_LAST);

	// count boot cycles, pulse done on the last one
	assign cnt_next = start_in ? '0 : (busy_out ? cnt_reg + 1'b1 : cnt_reg);
	assign busy_next = start_in | (busy_out & ~at_last);
	// done straight from the count, so the boot state lasts exactly the boot count
	assign done_out = at_last;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_reg <= '0;
			busy_out <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			busy_out <= busy_next;
		end
	end
endmodule // srsc_boot_timer

// *** srsc_ctrl.sv ***
module srsc_ctrl (
	// clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic RST_IN,
	// register access port
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic [7:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic REG_VIA_I2C_IN,
	output logic [7:0] REG_RDATA_OUT,
	output logic REG_WR_ACK_OUT,
	// hardware reset pin and mode state
	input wire logic RST_PIN_IN,
	input wire logic ACTIVE_IN,
	input wire logic SLEEP_IN,
	// control outputs
	output logic STANDBY_REQ_OUT,
	output logic BOOT_OUT,
	output logic SERIF_RST_OUT,
	output logic SELF_TEST_OUT,
	output logic AUTO_SLEEP_EN_OUT,
	output logic [1:0] OSR_MODE_OUT,
	output logic FIFO_FLUSH_OUT,
	output logic DEBOUNCE_CLR_OUT
);
	// register and sequencer state
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	srsc_pkg::srsc_state_t state_reg;
	srsc_pkg::srsc_state_t state_next;

	// one-cycle history of the level inputs, for edge detection
	logic pin_reg;
	logic sleep_reg;

	// boot timer handshake
	logic boot_start;
	logic boot_done;

	////////////////////////////////////////////////////////////////////////
	// decode
	// address match and sequencer idle flag
	wire addr_hit = (REG_ADDR_IN == srsc_pkg::CTRL_ADDR);
	wire in_idle = (state_reg == srsc_pkg::SEQ_IDLE);

	// writes are held off while a reset sequence runs, so a host that ignores
	// the quiet time cannot disturb the register in mid-boot
	wire wr_hit = REG_WR_IN & addr_hit & in_idle; // port held off during reset

	// reset sources: rst bit in a write, or a rising edge on the pin; a pin
	// already high when reset is released counts as an edge
	wire sw_rst = wr_hit & REG_WDATA_IN[srsc_pkg::RST_BIT];
	wire hw_rst = RST_PIN_IN & ~pin_reg;
	wire rst_req = in_idle & (sw_rst | hw_rst);

	// mode register reports standby while its active bit is clear
	wire standby = ~ACTIVE_IN;

	// a sleep/wake change counts only with auto-sleep enabled; the history
	// flop keeps flush and debounce clear to one cycle per change
	wire sleep_edge = ctrl_reg[srsc_pkg::SLPE_BIT] & (SLEEP_IN ^ sleep_reg);

	// power mode follows the sleep field in sleep, the wake field otherwise
	wire [1:0] smods = ctrl_reg[srsc_pkg::SMODS_LSB +: 2];
	wire [1:0] mods = ctrl_reg[srsc_pkg::MODS_LSB +: 2];
	wire [1:0] osr_sel = SLEEP_IN ? smods : mods;

	// read mux: only the control address answers with data
	wire [7:0] rdata = addr_hit ? ctrl_reg : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// sequencer next state
	// idle: waits for a reset request from a write or from the pin
	// standby wait: holds the standby request until the mode bit reads standby
	// boot: defaults reloaded, back to idle when the timer runs out
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			srsc_pkg::SEQ_IDLE: begin
				if (rst_req) begin
					state_next = standby ? srsc_pkg::SEQ_BOOT : srsc_pkg::SEQ_STBY;
				end
			end
			srsc_pkg::SEQ_STBY: begin
				if (standby) begin
					state_next = srsc_pkg::SEQ_BOOT;
				end
			end
			srsc_pkg::SEQ_BOOT: begin
				if (boot_done) begin
					state_next = srsc_pkg::SEQ_IDLE;
				end
			end
			// an illegal code falls back to idle
			default: state_next = srsc_pkg::SEQ_IDLE;
		endcase
	end

	// boot timer starts on entry to the boot state, from idle or from standby wait;
	// its done flag ends the boot state once the full count has run
	assign boot_start = (state_next == srsc_pkg::SEQ_BOOT) & (state_reg != srsc_pkg::SEQ_BOOT);

	// next values of the registered outputs
	wire seq_busy_next = (state_next != srsc_pkg::SEQ_IDLE);
	wire seq_boot_next = (state_next == srsc_pkg::SEQ_BOOT);
	// the byte that carries a reset over i2c is left unanswered
	wire ack_next = REG_WR_IN & ~(sw_rst & REG_VIA_I2C_IN);

	// register next value: write, hold rst while busy, clear at boot end
	// later assignments win: boot start and boot end override a write in the
	// same cycle, so the rst bit reads back as the sequence really stands
	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_hit) begin
			ctrl_next = REG_WDATA_IN;
		end
		// pin reset marks the rst bit so a read during the sequence shows it
		if (hw_rst & in_idle) begin
			ctrl_next[srsc_pkg::RST_BIT] = 1'b1;
		end
		if (boot_start) begin
			ctrl_next = srsc_pkg::CTRL_RESET;
			ctrl_next[srsc_pkg::RST_BIT] = 1'b1;
		end
		if (boot_done) begin
			ctrl_next = srsc_pkg::CTRL_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// boot duration timer; its busy flag is not needed, the boot state says the same
	// the timer shares the block's asynchronous reset
	srsc_boot_timer u_boot (
		.clk_in(CLK_SYS_IN),
		.rst_in(RST_IN),
		.start_in(boot_start),
		.busy_out(),
		.done_out(boot_done)
	);

	////////////////////////////////////////////////////////////////////////
	// state and output registers

	// state, register and edge history; the history flops reset low, the idle
	// level of both pins, so releasing reset with both pins low makes no edge
	always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state_reg <= srsc_pkg::SEQ_IDLE;
			ctrl_reg <= srsc_pkg::CTRL_RESET;
			pin_reg <= 1'b0;
			sleep_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ctrl_reg <= ctrl_next;
			pin_reg <= RST_PIN_IN;
			sleep_reg <= SLEEP_IN;
		end
	end

	// bus answer: read data and write acknowledge
	// read data holds until the next read strobe; every write is answered,
	// a refused one too, except the reset byte that came over i2c
	always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
		if (RST_IN) begin
			REG_RDATA_OUT <= 8'h00;
			REG_WR_ACK_OUT <= 1'b0;
		end else begin
			if (REG_RD_IN) begin
				REG_RDATA_OUT <= rdata;
			end
			REG_WR_ACK_OUT <= ack_next;
		end
	end

	// sequencing outputs
	// standby request and interface reset share the sequencer's busy span
	always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
		if (RST_IN) begin
			STANDBY_REQ_OUT <= 1'b0;
			BOOT_OUT <= 1'b0;
			SERIF_RST_OUT <= 1'b0;
		end else begin
			STANDBY_REQ_OUT <= seq_busy_next;
			BOOT_OUT <= seq_boot_next;
			SERIF_RST_OUT <= seq_busy_next;
		end
	end

	// functional controls
	// self-test and auto-sleep follow the next register value, so they change
	// with the write; the power mode follows one cycle later
	always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
		if (RST_IN) begin
			SELF_TEST_OUT <= 1'b0;
			AUTO_SLEEP_EN_OUT <= 1'b0;
			OSR_MODE_OUT <= srsc_pkg::OSR_NORMAL;
			FIFO_FLUSH_OUT <= 1'b0;
			DEBOUNCE_CLR_OUT <= 1'b0;
		end else begin
			SELF_TEST_OUT <= ctrl_next[srsc_pkg::SELF_TEST_BIT];
			AUTO_SLEEP_EN_OUT <= ctrl_next[srsc_pkg::SLPE_BIT];
			OSR_MODE_OUT <= osr_sel;
			FIFO_FLUSH_OUT <= sleep_edge;
			DEBOUNCE_CLR_OUT <= sleep_edge;
		end
	end
endmodule // srsc_ctrl

// *** srsc_checker.sv ***
module srsc_checker (
	input wire logic CLK_SYS_IN,
	input wire logic RST_IN,
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic [7:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_VIA_I2C_IN,
	input wire logic REG_WR_ACK_OUT,
	input wire logic RST_PIN_IN,
	input wire logic ACTIVE_IN,
	input wire logic SLEEP_IN,
	input wire logic STANDBY_REQ_OUT,
	input wire logic BOOT_OUT,
	input wire logic SERIF_RST_OUT,
	input wire logic AUTO_SLEEP_EN_OUT,
	input wire logic FIFO_FLUSH_OUT
);
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (RST_IN);
	// reset request written while idle
	wire logic rq = REG_WR_IN && REG_ADDR_IN == srsc_pkg::CTRL_ADDR
		&& REG_WDATA_IN[srsc_pkg::RST_BIT] && !STANDBY_REQ_OUT;
	////////////////////////////////
	// write answer, sequencing and flush checks
	a_spi_wr_ack: assert property (REG_WR_IN && !REG_VIA_I2C_IN |=> REG_WR_ACK_OUT)
		else $error("write not acked");
	a_i2c_no_ack: assert property (rq && REG_VIA_I2C_IN |=> !REG_WR_ACK_OUT)
		else $error("reset byte acked");
	a_soft_rst_go: assert property (rq |=> STANDBY_REQ_OUT && SERIF_RST_OUT)
		else $error("soft reset not started");
	a_pin_rst_go: assert property ($rose(RST_PIN_IN) && !STANDBY_REQ_OUT |=> SERIF_RST_OUT)
		else $error("pin reset not started");
	a_boot_stby: assert property ($rose(BOOT_OUT) |-> !$past(ACTIVE_IN))
		else $error("boot while active");
	a_boot_len: assert property ($rose(BOOT_OUT) |-> BOOT_OUT[*8] ##1 BOOT_OUT[*8]
		##1 !(BOOT_OUT || STANDBY_REQ_OUT || SERIF_RST_OUT)) else $error("boot length");
	a_stby_hold: assert property (STANDBY_REQ_OUT && !BOOT_OUT |=> STANDBY_REQ_OUT)
		else $error("standby dropped");
	a_flush_pulse: assert property (AUTO_SLEEP_EN_OUT && $changed(SLEEP_IN) |=> FIFO_FLUSH_OUT)
		else $error("no flush");
endmodule // srsc_checker

bind srsc_ctrl srsc_checker srsc_checker_i (.*);

// *** srsc_host_model.sv ***
module srsc_host_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic set_in,
	input wire logic stby_in,
	output logic act_out
);
	logic seen_reg;
	// mode bit: clears one cycle late on a standby request
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			act_out <= 1'b0;
			seen_reg <= 1'b0;
		end else begin
			seen_reg <= stby_in;
			if (set_in) act_out <= 1'b1;
			else if (seen_reg) act_out <= 1'b0;
		end
	end
endmodule // srsc_host_model

// *** test_soft_reset_selftest_ctrl.sv ***
module test_soft_reset_selftest_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, wr = 0, rd = 0, via = 0, pin = 0, slp = 0, set = 0;
	logic [7:0] addr = 8'h2b, wd = 8'h00, rdat;
	logic ack, stby, boot, serif, selftest, aslp, act, fl, db;
	logic [1:0] osr;
	int err_total = 0, num_checks = 0;
	// byte written, then self-test, auto-sleep, wake mode
	logic [11:0] rows [4] = '{12'h85d, 12'h022, 12'ha3b, 12'h380};
	always #2 clk = ~clk;
	srsc_ctrl srsc_ctrl_i (.CLK_SYS_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr),
		.REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_VIA_I2C_IN(via),
		.REG_RDATA_OUT(rdat), .REG_WR_ACK_OUT(ack), .RST_PIN_IN(pin), .ACTIVE_IN(act),
		.SLEEP_IN(slp), .STANDBY_REQ_OUT(stby), .BOOT_OUT(boot), .SERIF_RST_OUT(serif),
		.SELF_TEST_OUT(selftest), .AUTO_SLEEP_EN_OUT(aslp), .OSR_MODE_OUT(osr),
		.FIFO_FLUSH_OUT(fl), .DEBOUNCE_CLR_OUT(db));
	srsc_host_model srsc_host_model_i (.clk_in(clk), .rst_in(rst), .set_in(set),
		.stby_in(stby), .act_out(act));
	////////////////////////////////
	task automatic chk(input logic [7:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr8(input logic [7:0] a, d, input logic i);
		@(negedge clk);
		{addr, wd, via, wr} = {a, d, i, 1'b1};
		@(negedge clk);
		{via, wr} = 2'b00;
	endtask
	task automatic rd8(input logic [7:0] a);
		@(negedge clk);
		{addr, rd} = {a, 1'b1};
		@(negedge clk);
		rd = 0;
	endtask
	// stay off the port until the sequence ends, then read back
	task automatic idle_wait();
		for (int n = 0; n < 99 && stby !== 1'b0; n++) @(negedge clk);
		chk({7'h0, stby}, 8'h00);
		rd8(8'h2b);
		chk(rdat, 8'h00);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////
	// main sequence
	initial begin
		repeat (20) @(negedge clk);
		rst = 0;
		rd8(8'h2b);
		chk(rdat, 8'h00);
		foreach (rows[k]) begin
			wr8(8'h2b, rows[k][11:4], 1'b0);
			chk({7'h0, ack}, 8'h01);
			rd8(8'h2b);
			chk(rdat, rows[k][11:4]);
			chk({selftest, aslp, osr}, rows[k][3:0]);
		end
		wr8(8'h11, 8'hff, 1'b0);
		rd8(8'h11);
		chk(rdat, 8'h00);
		$display("register rows done");
		wr8(8'h2b, 8'h0e, 1'b0);
		slp = 1;
		@(negedge clk);
		chk({fl, db}, 2'b11);
		@(negedge clk);
		chk({fl, osr}, 3'b001);
		slp = 0;
		$display("sleep flush done");
		wr8(8'h2b, 8'hc0, 1'b0);
		chk({ack, stby, serif, boot}, 4'hf);
		idle_wait();
		chk({7'h0, selftest}, 8'h00);
		set = 1;
		@(negedge clk);
		set = 0;
		wr8(8'h2b, 8'h45, 1'b1); // no ack awaited after this byte
		chk({ack, stby, boot}, 3'b010);
		idle_wait();
		pin = 1;
		@(negedge clk);
		pin = 0;
		chk({7'h0, serif}, 8'h01);
		idle_wait();
		$display("reset sequences done");
		// reset in mid-run, while a boot is under way
		wr8(8'h2b, 8'hc4, 1'b0);
		rst = 1;
		repeat (2) @(negedge clk);
		chk({4'h0, stby, serif, boot, selftest}, 8'h00);
		rst = 0;
		@(negedge clk);
		chk({4'h0, stby, serif, boot, aslp}, 8'h00);
		rd8(8'h2b);
		chk(rdat, 8'h00);
		$display("mid-run reset done");
		tally_and_finish();
	end
	// cut a hang short, far beyond the expected run
	initial begin
		#10000;
		err_total++;
		tally_and_finish();
	end
endmodule // test_soft_reset_selftest_ctrl
